// [verilog/ubp_map.vh]
`ifndef UBP_MAP_VH
`define UBP_MAP_VH
// Oversampling and bit sample positions
`define UBP_OVS_LAST 4'hF
`define UBP_SMP_A 4'h7
`define UBP_SMP_B 4'h8
`define UBP_SMP_C 4'h9
`define UBP_SMP_E3 4'h2
`define UBP_SMP_E5 4'h4
`define UBP_SMP_E7 4'h6
// Common prescaler codes and factors minus one
`define UBP_PR_CODE_1 2'h0
`define UBP_PR_CODE_3 2'h1
`define UBP_PR_CODE_4 2'h2
`define UBP_PR_M1_1 4'h0
`define UBP_PR_M1_3 4'h2
`define UBP_PR_M1_4 4'h3
`define UBP_PR_M1_13 4'hC
// Frame bit counts (data plus stop, after start)
`define UBP_BITS_M0 4'h9
`define UBP_BITS_M1 4'hA
// Data bits per received word, parity included
`define UBP_DATA_M0 4'h8
`define UBP_DATA_M1 4'h9
// Idle frame length in bit times
`define UBP_IDLE_M0 4'hA
`define UBP_IDLE_M1 4'hB
`define UBP_HIGH_RUN 2'h3
`endif

// [verilog/ubp_rate_gen.v]
`timescale 1ns/1ps
// Sample tick: clk / prescaler / 2^div / fine; the 16 samples per bit give the /16
module ubp_rate_gen (
    input wire clk_i,
    input wire sys_rst_i,
    input wire run_i,
    input wire [3:0] pr_m1_i,
    input wire [2:0] div_sel_i,
    input wire [7:0] fine_i,
    output reg tick_o
);
`include "ubp_map.vh"
    reg [3:0] pr_cnt_ff;
    reg [6:0] div_cnt_ff;
    reg [7:0] fine_cnt_ff;
    wire pr_tc = (pr_cnt_ff == pr_m1_i);
    wire [6:0] div_m1 = (7'h01 << div_sel_i) - 7'h01;
    wire div_tc = pr_tc && (div_cnt_ff == div_m1);
    wire [7:0] fine_m1 = (fine_i == 8'h00) ? 8'h00 : fine_i - 8'h01;
    wire fine_tc = div_tc && (fine_cnt_ff >= fine_m1);
    // Chained dividers, each step enabled by the one before
    always @(posedge clk_i) begin
        if (sys_rst_i || !run_i) begin
            pr_cnt_ff <= 4'h0;
            div_cnt_ff <= 7'h00;
            fine_cnt_ff <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            pr_cnt_ff <= pr_tc ? 4'h0 : pr_cnt_ff + 4'h1;
            if (pr_tc)
                div_cnt_ff <= div_tc ? 7'h00 : div_cnt_ff + 7'h01;
            if (div_tc)
                fine_cnt_ff <= fine_tc ? 8'h00 : fine_cnt_ff + 8'h01;
            tick_o <= fine_tc;
        end
    end
endmodule

// [verilog/ubp_core.v]
`timescale 1ns/1ps
module ubp_core (
    input wire clk_i,
    input wire sys_rst_i,
    input wire tx_enable_i,
    input wire rx_enable_i,
    input wire word_len_i,
    input wire wake_method_i,
    input wire parity_enable_i,
    input wire parity_odd_select_i,
    input wire parity_irq_enable_i,
    input wire [1:0] common_prescaler_select_i,
    input wire [2:0] tx_divider_select_i,
    input wire [2:0] rx_divider_select_i,
    input wire [7:0] tx_fine_prescaler_i,
    input wire [7:0] rx_fine_prescaler_i,
    input wire mute_set_i,
    input wire status_read_i,
    input wire data_read_i,
    input wire tx_load_i,
    input wire [8:0] tx_data_i,
    input wire serial_rx_pin_i,
    output reg serial_tx_pin_o,
    output reg tx_busy_o,
    output reg receiver_mute_o,
    output reg receive_full_flag_o,
    output reg framing_error_flag_o,
    output reg noise_flag_o,
    output reg parity_error_flag_o,
    output reg parity_irq_o,
    output reg [8:0] serial_data_register_o
);
`include "ubp_map.vh"
    localparam RX_IDLE = 3'b001;
    localparam RX_START = 3'b010;
    localparam RX_DATA = 3'b100;

    reg [3:0] pr_m1;
    wire tx_tick;
    wire rx_tick;

    // Common prescaler decode
    // four prescaler factors
    always @* begin
        if (common_prescaler_select_i == `UBP_PR_CODE_1)
            pr_m1 = `UBP_PR_M1_1;
        else if (common_prescaler_select_i == `UBP_PR_CODE_3)
            pr_m1 = `UBP_PR_M1_3;
        else if (common_prescaler_select_i == `UBP_PR_CODE_4)
            pr_m1 = `UBP_PR_M1_4;
        else
            pr_m1 = `UBP_PR_M1_13;
    end

    // Independent rate generators
    // separate tx rx
    ubp_rate_gen u_tx_rate (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(tx_enable_i),
        .pr_m1_i(pr_m1),
        .div_sel_i(tx_divider_select_i),
        .fine_i(tx_fine_prescaler_i),
        .tick_o(tx_tick)
    );
    ubp_rate_gen u_rx_rate (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(rx_enable_i),
        .pr_m1_i(pr_m1),
        .div_sel_i(rx_divider_select_i),
        .fine_i(rx_fine_prescaler_i),
        .tick_o(rx_tick)
    );

    // Transmitter: format latched at frame start
    reg [10:0] tx_shift_ff;
    reg [3:0] tx_bits_ff;
    reg [3:0] tx_ovs_ff;
    reg tx_par;
    reg [8:0] tx_word;
    always @* begin
        tx_word = tx_data_i;
        if (word_len_i) begin
            tx_par = (^tx_data_i[7:0]) ^ parity_odd_select_i;
            if (parity_enable_i)
                tx_word[8] = tx_par;
        end else begin
            tx_par = (^tx_data_i[6:0]) ^ parity_odd_select_i;
            tx_word[8] = 1'b1;
            if (parity_enable_i)
                tx_word[7] = tx_par;
        end
    end

    // Transmit shifter, lsb first
    // start data stop
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_shift_ff <= 11'h7FF;
            tx_bits_ff <= 4'h0;
            tx_ovs_ff <= 4'h0;
            tx_busy_o <= 1'b0;
            serial_tx_pin_o <= 1'b1;
        end else if (!tx_busy_o) begin
            serial_tx_pin_o <= 1'b1;
            if (tx_load_i && tx_enable_i) begin
                tx_shift_ff <= {1'b1, tx_word, 1'b0};
                tx_bits_ff <= word_len_i ? `UBP_BITS_M1 : `UBP_BITS_M0;
                tx_ovs_ff <= 4'h0;
                tx_busy_o <= 1'b1;
            end
        end else if (tx_tick) begin
            serial_tx_pin_o <= tx_shift_ff[0];
            tx_ovs_ff <= tx_ovs_ff + 4'h1;
            if (tx_ovs_ff == `UBP_OVS_LAST) begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                if (tx_bits_ff == 4'h0)
                    tx_busy_o <= 1'b0;
                else
                    tx_bits_ff <= tx_bits_ff - 4'h1;
            end
        end
    end

    // Receiver state
    reg [2:0] rx_state_ff;
    reg [3:0] rx_ovs_ff;
    reg [3:0] rx_bits_ff;
    reg [8:0] rx_shift_ff;
    reg [1:0] high_run_ff;
    reg edge_ok_ff;
    reg [2:0] smp_ff;
    reg noise_acc_ff;
    reg noise_pend_ff;
    reg fmt_m_ff;
    reg fmt_pce_ff;
    reg fmt_ps_ff;
    reg [3:0] idle_cnt_ff;
    reg rd_armed_ff;

    wire vote = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) | (smp_ff[0] & smp_ff[2]);
    wire disagree = ~(&smp_ff) & (|smp_ff);
    wire at_eval = rx_tick && (rx_ovs_ff == `UBP_SMP_C + 4'h1);
    wire [3:0] data_bits = fmt_m_ff ? `UBP_DATA_M1 : `UBP_DATA_M0;
    wire last_bit = (rx_bits_ff == data_bits);
    wire [8:0] rx_word = fmt_m_ff ? rx_shift_ff : {1'b0, rx_shift_ff[8:1]};
    wire rx_msb = fmt_pce_ff ? (fmt_m_ff ? rx_word[7] : rx_word[6]) :
        (fmt_m_ff ? rx_word[8] : rx_word[7]);
    wire rx_par_bad = fmt_pce_ff &&
        ((fmt_m_ff ? ^rx_word[8:0] : ^rx_word[7:0]) != fmt_ps_ff);
    wire clr_seq = rd_armed_ff && data_read_i;
    wire [3:0] idle_len = word_len_i ? `UBP_IDLE_M1 : `UBP_IDLE_M0;

    // Status-then-data read sequence arming
    // read sequence
    always @(posedge clk_i) begin
        if (sys_rst_i)
            rd_armed_ff <= 1'b0;
        else if (status_read_i)
            rd_armed_ff <= 1'b1;
        else if (data_read_i)
            rd_armed_ff <= 1'b0;
    end

    // Receive sampling, framing, flags and wake
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_state_ff <= RX_IDLE;
            rx_ovs_ff <= 4'h0;
            rx_bits_ff <= 4'h0;
            rx_shift_ff <= 9'h000;
            high_run_ff <= 2'h0;
            edge_ok_ff <= 1'b0;
            smp_ff <= 3'h0;
            noise_acc_ff <= 1'b0;
            noise_pend_ff <= 1'b0;
            fmt_m_ff <= 1'b0;
            fmt_pce_ff <= 1'b0;
            fmt_ps_ff <= 1'b0;
            idle_cnt_ff <= 4'h0;
            receiver_mute_o <= 1'b0;
            receive_full_flag_o <= 1'b0;
            framing_error_flag_o <= 1'b0;
            noise_flag_o <= 1'b0;
            parity_error_flag_o <= 1'b0;
            parity_irq_o <= 1'b0;
            serial_data_register_o <= 9'h000;
        end else begin
            // Software clear; a same-cycle set below wins
            if (clr_seq) begin
                receive_full_flag_o <= 1'b0;
                framing_error_flag_o <= 1'b0;
                noise_flag_o <= 1'b0;
                parity_error_flag_o <= 1'b0;
                parity_irq_o <= 1'b0;
            end
            if (mute_set_i)
                receiver_mute_o <= 1'b1;
            if (rx_enable_i && rx_tick) begin
                rx_ovs_ff <= rx_ovs_ff + 4'h1;
                if (rx_ovs_ff == `UBP_SMP_A)
                    smp_ff[0] <= serial_rx_pin_i;
                if (rx_ovs_ff == `UBP_SMP_B)
                    smp_ff[1] <= serial_rx_pin_i;
                if (rx_ovs_ff == `UBP_SMP_C)
                    smp_ff[2] <= serial_rx_pin_i;
                case (rx_state_ff)
                RX_IDLE: begin
                    high_run_ff <= serial_rx_pin_i ?
                        ((high_run_ff == `UBP_HIGH_RUN) ? high_run_ff : high_run_ff + 2'h1)
                        : 2'h0;
                    // Idle frame counted in whole bit times
                    if (!serial_rx_pin_i)
                        idle_cnt_ff <= 4'h0;
                    else if (rx_ovs_ff == `UBP_OVS_LAST && idle_cnt_ff != idle_len)
                        idle_cnt_ff <= idle_cnt_ff + 4'h1;
                    if (serial_rx_pin_i && rx_ovs_ff == `UBP_OVS_LAST &&
                        idle_cnt_ff == idle_len - 4'h1 && !wake_method_i)
                        receiver_mute_o <= 1'b0;
                    if (!serial_rx_pin_i) begin
                        rx_ovs_ff <= 4'h1;
                        edge_ok_ff <= (high_run_ff == `UBP_HIGH_RUN);
                        rx_state_ff <= RX_START;
                        fmt_m_ff <= word_len_i;
                        fmt_pce_ff <= parity_enable_i;
                        fmt_ps_ff <= parity_odd_select_i;
                    end
                end
                RX_START: begin
                    if ((rx_ovs_ff == `UBP_SMP_E3 || rx_ovs_ff == `UBP_SMP_E5 ||
                        rx_ovs_ff == `UBP_SMP_E7) && serial_rx_pin_i)
                        edge_ok_ff <= 1'b0;
                    if (at_eval) begin
                        noise_acc_ff <= noise_pend_ff | ~edge_ok_ff | (|smp_ff);
                        if (vote) begin
                            noise_pend_ff <= 1'b1;
                            rx_state_ff <= RX_IDLE;
                            high_run_ff <= 2'h0;
                        end else begin
                            rx_bits_ff <= 4'h0;
                            rx_state_ff <= RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_ovs_ff == `UBP_OVS_LAST)
                        rx_ovs_ff <= 4'h0;
                    if (at_eval && !last_bit) begin
                        rx_shift_ff <= {vote, rx_shift_ff[8:1]};
                        noise_acc_ff <= noise_acc_ff | disagree;
                        rx_bits_ff <= rx_bits_ff + 4'h1;
                    end
                    if (at_eval && last_bit) begin
                        rx_state_ff <= RX_IDLE;
                        high_run_ff <= 2'h0;
                        idle_cnt_ff <= 4'h0;
                        if (!receiver_mute_o || (wake_method_i && rx_msb)) begin
                            receiver_mute_o <= 1'b0;
                            noise_pend_ff <= 1'b0;
                            serial_data_register_o <= rx_word;
                            receive_full_flag_o <= 1'b1;
                            framing_error_flag_o <= ~vote;
                            noise_flag_o <= noise_acc_ff | disagree;
                            parity_error_flag_o <= rx_par_bad;
                            parity_irq_o <= rx_par_bad & parity_irq_enable_i;
                        end
                    end
                end
                default: rx_state_ff <= RX_IDLE;
                endcase
            end
        end
    end
endmodule

// [tb/ubp_core_sva.sv]
`timescale 1ns/1ps
// Port-level checks on the serial core
module ubp_core_sva (
    input wire clk_i,
    input wire sys_rst_i,
    input wire tx_enable_i,
    input wire wake_method_i,
    input wire data_read_i,
    input wire tx_load_i,
    input wire serial_tx_pin_o,
    input wire tx_busy_o,
    input wire receiver_mute_o,
    input wire receive_full_flag_o,
    input wire framing_error_flag_o,
    input wire noise_flag_o,
    input wire parity_error_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_load_sets_busy: assert property (tx_load_i && tx_enable_i && !tx_busy_o |=> tx_busy_o)
        else $error("busy missing after load");
    a_tx_idle_high: assert property (!tx_busy_o |-> serial_tx_pin_o)
        else $error("tx line low while idle");
    a_framing_with_full: assert property ($rose(framing_error_flag_o) |-> $rose(receive_full_flag_o))
        else $error("framing flag rose alone");
    a_noise_with_full: assert property ($rose(noise_flag_o) |-> $rose(receive_full_flag_o))
        else $error("noise flag rose alone");
    a_parity_with_full: assert property ($rose(parity_error_flag_o) |-> $rose(receive_full_flag_o))
        else $error("parity flag rose alone");
    a_mute_no_status: assert property ($rose(receive_full_flag_o) |-> ##[0:1] !receiver_mute_o)
        else $error("status set while muted");
    a_framing_clear_read: assert property ($fell(framing_error_flag_o) |-> $past(data_read_i) || $past(data_read_i, 2))
        else $error("framing flag cleared without data read");
    a_address_wake_full: assert property ($fell(receiver_mute_o) && wake_method_i |-> ##[0:2] receive_full_flag_o)
        else $error("address wake without receive full");
    c_framing: cover property ($rose(framing_error_flag_o));
    c_addr_wake: cover property ($fell(receiver_mute_o) && wake_method_i);
    c_idle_wake: cover property ($fell(receiver_mute_o) && !wake_method_i);
endmodule
bind ubp_core ubp_core_sva i_ubp_core_sva (.clk_i, .sys_rst_i, .tx_enable_i, .wake_method_i,
    .data_read_i, .tx_load_i, .serial_tx_pin_o, .tx_busy_o, .receiver_mute_o, .receive_full_flag_o,
    .framing_error_flag_o, .noise_flag_o, .parity_error_flag_o);

// [tb/ubp_remote.sv]
`timescale 1ns/1ps
// Far serial party: sends frames to the receiver, samples the transmitter
module ubp_remote (
    input wire clk_i,
    input wire serial_tx_pin_i,
    output reg serial_rx_pin_o
);
    // Line rests high as with its pull-up
    initial serial_rx_pin_o = 1'b1;
    // sixteen samples per bit
    // Bits lsb first, s clocks per sample; sample 8 of bit g inverted
    task send(input [11:0] bits, input integer n, input integer s, input integer g);
        integer b;
        integer q;
        begin
            for (b = 0; b < n * 16 * s; b = b + 1) begin
                q = b / s;
                serial_rx_pin_o <= (q / 16 == g && q % 16 == 8) ? ~bits[q / 16] : bits[q / 16];
                @(negedge clk_i);
            end
            serial_rx_pin_o <= 1'b1;
            @(negedge clk_i);
        end
    endtask
    // Mid-bit samples of one frame; lo counts clocks of the first low run
    task recv(input integer n, input integer bl, output [11:0] v, output integer lo);
        integer b;
        begin
            v = 12'h000;
            @(negedge serial_tx_pin_i);
            lo = 0;
            for (b = 0; b < n * bl; b = b + 1) begin
                @(negedge clk_i);
                if (b % bl == bl / 2)
                    v[b / bl] = serial_tx_pin_i;
                if (serial_tx_pin_i === 1'b0 && lo == b)
                    lo = b + 1;
            end
        end
    endtask
endmodule

// [tb/test_ubp_core.sv]
`timescale 1ns/1ps
module test_ubp_core;
    reg clk_i, sys_rst_i, tx_enable_i, rx_enable_i, word_len_i, wake_method_i, parity_enable_i;
    reg parity_odd_select_i, parity_irq_enable_i, mute_set_i, status_read_i, data_read_i;
    reg tx_load_i, par_err;
    reg [1:0] common_prescaler_select_i;
    reg [2:0] tx_divider_select_i, rx_divider_select_i;
    reg [7:0] tx_fine_prescaler_i, rx_fine_prescaler_i;
    reg [8:0] tx_data_i, d, dat;
    reg [11:0] v, e;
    reg [31:0] seed;
    wire serial_rx_pin_i, serial_tx_pin_o, tx_busy_o, receiver_mute_o, receive_full_flag_o;
    wire framing_error_flag_o, noise_flag_o, parity_error_flag_o, parity_irq_o;
    wire [8:0] serial_data_register_o;
    integer mismatches, checked, k, w, bl, lo;
    integer prf [0:3] = '{1, 3, 4, 13};
    ubp_core i_ubp_core (.clk_i, .sys_rst_i, .tx_enable_i, .rx_enable_i, .word_len_i,
        .wake_method_i, .parity_enable_i, .parity_odd_select_i, .parity_irq_enable_i,
        .common_prescaler_select_i, .tx_divider_select_i, .rx_divider_select_i,
        .tx_fine_prescaler_i, .rx_fine_prescaler_i, .mute_set_i, .status_read_i, .data_read_i,
        .tx_load_i, .tx_data_i, .serial_rx_pin_i, .serial_tx_pin_o, .tx_busy_o, .receiver_mute_o,
        .receive_full_flag_o, .framing_error_flag_o, .noise_flag_o, .parity_error_flag_o,
        .parity_irq_o, .serial_data_register_o);
    ubp_remote i_ubp_remote (.clk_i, .serial_tx_pin_i(serial_tx_pin_o),
        .serial_rx_pin_o(serial_rx_pin_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string nm, input [11:0] exp, input [11:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Status read then data read
    task rd;
        begin
            status_read_i = 1'b1;
            @(negedge clk_i);
            status_read_i = 1'b0;
            data_read_i = 1'b1;
            @(negedge clk_i);
            data_read_i = 1'b0;
        end
    endtask
    // One received frame at four clocks per sample
    task rxf(input [8:0] dd, input st, input integer g);
        if (word_len_i)
            i_ubp_remote.send({1'b0, st, dd, 1'b0}, 11, 4, g);
        else
            i_ubp_remote.send({2'b00, st, dd[7:0], 1'b0}, 10, 4, g);
    endtask
    // mute set only by this strobe, never after a pending wake
    task mute_on;
        begin
            mute_set_i = 1'b1;
            @(negedge clk_i);
            mute_set_i = 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            if (mismatches == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        #400000;
        mismatches = mismatches + 1;
        report_and_stop;
    end
    initial begin
        seed = 32'hD7AE771C;
        mismatches = 0;
        checked = 0;
        sys_rst_i = 1'b1;
        {tx_enable_i, rx_enable_i, word_len_i, wake_method_i, parity_enable_i} = 5'h00;
        {parity_odd_select_i, parity_irq_enable_i, mute_set_i, status_read_i, data_read_i} = 5'h00;
        {tx_load_i, common_prescaler_select_i, tx_divider_select_i, rx_divider_select_i} = 9'h000;
        {tx_fine_prescaler_i, tx_data_i} = 17'h00000;
        rx_fine_prescaler_i = 8'h04;
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        {tx_enable_i, rx_enable_i} = 2'h3;
        // Every format, a break, a noisy bit, parity both ways, then clearing
        for (k = 0; k < 8; k = k + 1) begin
            repeat (16) @(negedge clk_i);
            seed = lfsr(seed);
            d = (k == 5) ? 9'h000 : seed[8:0];
            {parity_irq_enable_i, parity_odd_select_i, parity_enable_i, word_len_i} = {seed[9], k[2:0]};
            rxf(d, k != 5, (k == 6) ? 3 : 99);
            dat = word_len_i ? d : {1'b0, d[7:0]};
            par_err = parity_enable_i & (^dat ^ parity_odd_select_i);
            chk("rx_data", 12'(dat), 12'(serial_data_register_o));
            chk("rx_flags", 12'({1'b1, k == 5, k == 6, par_err, par_err & parity_irq_enable_i}),
                12'({receive_full_flag_o, framing_error_flag_o, noise_flag_o, parity_error_flag_o,
                parity_irq_o}));
            if (k == 5) begin
                status_read_i = 1'b1;
                @(negedge clk_i);
                status_read_i = 1'b0;
                @(negedge clk_i);
                chk("frame_hold", 12'h001, 12'(framing_error_flag_o));
            end
            rd;
            chk("cleared", 12'h000, 12'({receive_full_flag_o, framing_error_flag_o, noise_flag_o}));
        end
        // Short start pulse is dropped, its noise shows on the next frame
        i_ubp_remote.serial_rx_pin_o <= 1'b0;
        repeat (20) @(negedge clk_i);
        i_ubp_remote.serial_rx_pin_o <= 1'b1;
        repeat (800) @(negedge clk_i);
        chk("false_start", 12'h000, 12'(receive_full_flag_o));
        rxf(9'h0A5, 1'b1, 99);
        chk("noise_pend", 12'h003, 12'({receive_full_flag_o, noise_flag_o}));
        rd;
        // Address mark wake, seven data bits plus even parity
        {word_len_i, parity_enable_i, parity_odd_select_i, wake_method_i} = 4'h5;
        mute_on;
        rxf(9'h080, 1'b1, 99);
        chk("muted", 12'h002, 12'({receiver_mute_o, receive_full_flag_o}));
        rxf(9'h041, 1'b1, 99);
        chk("woken", 12'h002, 12'({receiver_mute_o, receive_full_flag_o, parity_error_flag_o}));
        chk("addr", 12'h041, 12'(serial_data_register_o));
        rd;
        // Idle line wake
        wake_method_i = 1'b0;
        mute_on;
        rxf(9'h012, 1'b1, 99);
        chk("idle_mute", 12'h002, 12'({receiver_mute_o, receive_full_flag_o}));
        repeat (800) @(negedge clk_i);
        chk("idle_wake", 12'h000, 12'({receiver_mute_o, receive_full_flag_o}));
        // Transmit every prescaler code with divider and fine steps
        for (k = 0; k < 4; k = k + 1) begin
            // rates change only while both directions are disabled
            {tx_enable_i, rx_enable_i} = 2'h0;
            @(negedge clk_i);
            seed = lfsr(seed);
            common_prescaler_select_i = k[1:0];
            tx_divider_select_i = {2'b00, k[0]};
            rx_divider_select_i = seed[15:13];
            tx_fine_prescaler_i = (k == 2) ? 8'h03 : 8'h00;
            bl = 16 * prf[k] * (k % 2 + 1) * ((k == 2) ? 3 : 1);
            {tx_enable_i, rx_enable_i} = 2'h3;
            {parity_odd_select_i, parity_enable_i, word_len_i} = seed[12:10];
            d = seed[8:0] | 9'h001;
            if (word_len_i)
                e = {2'b01, parity_enable_i ? parity_odd_select_i ^ (^d[7:0]) : d[8], d[7:0], 1'b0};
            else
                e = {3'b001, parity_enable_i ? parity_odd_select_i ^ (^d[6:0]) : d[7], d[6:0], 1'b0};
            for (w = 0; w < 6000 && tx_busy_o !== 1'b0; w = w + 1)
                @(negedge clk_i);
            fork
                i_ubp_remote.recv(10 + word_len_i, bl, v, lo);
                begin
                    tx_load_i = 1'b1;
                    tx_data_i = d;
                    @(negedge clk_i);
                    tx_load_i = 1'b0;
                end
            join
            chk("tx_frame", e, v);
            chk("bit_len", 12'(bl), 12'(lo));
        end
        report_and_stop;
    end
endmodule
